// [core/gar_pkg.sv]
package gar_pkg;

	// ------------------------------------------------------------
	// Sizes and timing
	// ------------------------------------------------------------
	localparam int          NUM_ATTR       = 4;
	localparam int          ATTR_W         = 2;
	localparam int          CLK_HZ         = 50000000;
	localparam int          TICK_US        = 1000;
	localparam int          TICK_CYCLES    = (CLK_HZ / 1000000) * TICK_US;
	localparam int          TICK_W         = 16;
	localparam logic [7:0]  LEAVE_TICKS    = 8'h3C;
	localparam int          CNT_W          = 8;

	// ------------------------------------------------------------
	// Message codes on the transmit and receive ports
	// ------------------------------------------------------------
	localparam logic [2:0]  MSG_NONE       = 3'h0;
	localparam logic [2:0]  MSG_JOIN_IN    = 3'h1;
	localparam logic [2:0]  MSG_JOIN_EMPTY = 3'h2;
	localparam logic [2:0]  MSG_LEAVE      = 3'h3;
	localparam logic [2:0]  MSG_LEAVE_ALL  = 3'h4;
	localparam logic [2:0]  MSG_EMPTY      = 3'h5;

	// ------------------------------------------------------------
	// Applicant states, Gray along VO-VP-AA-QA; reduced uses VO-VP-AA-QA too
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		APP_VO = 3'h0,
		APP_VP = 3'h1,
		APP_AA = 3'h3,
		APP_QA = 3'h2,
		APP_PM = 3'h6
	} gar_app_type;

	// Registrar states
	typedef enum logic [1:0] {
		REG_MT = 2'h0,
		REG_IN = 2'h1,
		REG_LV = 2'h3
	} gar_reg_type;

	// Registrar reports registration in IN or LV only
	function automatic logic gar_registered(input gar_reg_type s);
		return (s == REG_IN) || (s == REG_LV);
	endfunction

endpackage

// [core/gar_tick.sv]
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Periodic tick divider
// ------------------------------------------------------------
module gar_tick
	import gar_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      tick
);

	logic [TICK_W-1:0] cnt_q;

	// Free-running divider, one-cycle pulse at wrap
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end
		else if (cnt_q == TICK_W'(TICK_CYCLES - 1))
		begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + TICK_W'(1);
			tick  <= 1'b0;
		end
	end

endmodule // gar_tick

`default_nettype wire

// [core/gar_attr_reg.sv]
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Critical Join messages go out twice per join so one loss is survived.
// - Join flavour follows local registration (not reduced): JoinIn if registered, else JoinEmpty.
// - A QA member (not reduced) hearing JoinEmpty answers with a JoinIn.
// - Joining with no members (not reduced): two JoinEmpty, then settle in QA.
// - Joining with one other member registered: send two JoinIns.
// - Two joins heard (not reduced), even from one member: go passive member, silent join and leave.
// - Any received JoinEmpty moves the registrar to IN.
// - Reduced applicant option: two JoinIns to join, one Leave to leave.
// - Registrar never transmits anything.
// - Registered output true in IN or LV, false in MT.
// - LV falls to MT after LeaveTime with no Join heard meanwhile.
// - Join request moves VO to VP, waiting for a transmit chance.
// - Second Join sent at a later chance moves AA to QA, joins stop.

module gar_attr_reg
	import gar_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              reduced_mode,
	input  wire logic              join_req,
	input  wire logic              leave_req,
	input  wire logic [ATTR_W-1:0] req_attr,
	input  wire logic              rx_valid,
	input  wire logic [2:0]        rx_msg,
	input  wire logic [ATTR_W-1:0] rx_attr,
	input  wire logic              tx_opp,
	output logic                   tx_valid,
	output logic [2:0]             tx_msg,
	output logic [ATTR_W-1:0]      tx_attr,
	output logic [NUM_ATTR-1:0]    registered,
	output logic [NUM_ATTR-1:0]    member
);

	// ------------------------------------------------------------
	// Tick and per-attribute state
	// ------------------------------------------------------------
	logic                     tick;
	gar_app_type              app_q   [NUM_ATTR];
	gar_reg_type              reg_q   [NUM_ATTR];
	logic [CNT_W-1:0]         lv_q    [NUM_ATTR];
	logic [1:0]               heard_q [NUM_ATTR];
	logic                     lvpend_q[NUM_ATTR];
	logic                     answer_q[NUM_ATTR];
	logic [NUM_ATTR-1:0]      want;
	logic [ATTR_W-1:0]        sel;
	logic                     sel_ok;

	gar_tick u_tick
	(
		.clk   (clk),
		.rst_n (rst_n),
		.tick  (tick)
	);

	// Attribute wants the next transmit chance
	always_comb
	begin
		sel    = '0;
		sel_ok = 1'b0;
		for (int i = NUM_ATTR - 1; i >= 0; i--)
		begin
			want[i] = (app_q[i] == APP_VP) || (app_q[i] == APP_AA) ||
			          answer_q[i] || lvpend_q[i];
			if (want[i])
			begin
				sel    = ATTR_W'(i);
				sel_ok = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Per-attribute machines
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_ATTR; g++)
		begin : g_attr
			logic hit_rx;
			logic hit_req;
			logic sent;
			logic rx_join;
			assign hit_rx  = rx_valid && (rx_attr == ATTR_W'(g));
			assign hit_req = req_attr == ATTR_W'(g);
			assign sent    = tx_opp && sel_ok && (sel == ATTR_W'(g));
			assign rx_join = hit_rx && ((rx_msg == MSG_JOIN_IN) || (rx_msg == MSG_JOIN_EMPTY));

			// Count every join heard, saturating at two; LeaveAll clears it
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					heard_q[g] <= 2'h0;
				else if (hit_rx && (rx_msg == MSG_LEAVE_ALL))
					heard_q[g] <= 2'h0;
				else if (rx_join && heard_q[g] != 2'h2)
					heard_q[g] <= heard_q[g] + 2'h1;
			end

			// Registrar: passive, it only records state
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					reg_q[g] <= REG_MT;
					lv_q[g]  <= '0;
				end
				else if (rx_join)
					reg_q[g] <= REG_IN;
				else if (hit_rx && (rx_msg == MSG_LEAVE || rx_msg == MSG_LEAVE_ALL)
				         && reg_q[g] != REG_MT)
				begin
					reg_q[g] <= REG_LV;
					lv_q[g]  <= LEAVE_TICKS;
				end
				else if (reg_q[g] == REG_LV && tick)
				begin
					if (lv_q[g] <= CNT_W'(1))
						reg_q[g] <= REG_MT;
					else
						lv_q[g] <= lv_q[g] - CNT_W'(1);
				end
			end

			// Pending answer to a JoinEmpty while in QA, not reduced; set wins over send
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					answer_q[g] <= 1'b0;
				else if (hit_rx && rx_msg == MSG_JOIN_EMPTY && app_q[g] == APP_QA
				         && !reduced_mode)
					answer_q[g] <= 1'b1;
				else if (sent)
					answer_q[g] <= 1'b0; // Any send retires it, so a leave cannot strand it
			end

			// Leave pending until the next send of this attribute; a rejoin supersedes it
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					lvpend_q[g] <= 1'b0;
				else if (leave_req && hit_req && (app_q[g] == APP_AA || app_q[g] == APP_QA))
					lvpend_q[g] <= 1'b1;
				else if (sent)
					lvpend_q[g] <= 1'b0;
			end

			// Applicant machine
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					app_q[g] <= APP_VO;
				else
				begin
					case (app_q[g])
						APP_VO:
						begin
							if (join_req && hit_req)
							begin
								if (!reduced_mode && heard_q[g] == 2'h2)
									app_q[g] <= APP_PM;
								else
									app_q[g] <= APP_VP;
							end
						end
						APP_VP:
							if (leave_req && hit_req)
								app_q[g] <= APP_VO;
							else if (sent)
								app_q[g] <= APP_AA;
						APP_AA:
							if (leave_req && hit_req)
								app_q[g] <= APP_VO;
							else if (sent)
								app_q[g] <= APP_QA;
						APP_QA:
							if (leave_req && hit_req)
								app_q[g] <= APP_VO;
						APP_PM:
							if (leave_req && hit_req)
								app_q[g] <= APP_VO;
						default:
							app_q[g] <= APP_VO;
					endcase
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Transmit port; only the applicant side drives it
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_valid <= 1'b0;
			tx_msg   <= MSG_NONE;
			tx_attr  <= '0;
		end
		else if (tx_opp && sel_ok)
		begin
			tx_valid <= 1'b1;
			tx_attr  <= sel;
			if (lvpend_q[sel] && app_q[sel] == APP_VO)
				tx_msg <= MSG_LEAVE;
			else if (reduced_mode || gar_registered(reg_q[sel]))
				tx_msg <= MSG_JOIN_IN;
			else
				tx_msg <= MSG_JOIN_EMPTY;
		end
		else
		begin
			tx_valid <= 1'b0;
			tx_msg   <= MSG_NONE;
		end
	end

	// Status outputs, registered; registrar state reaches tx only through the JoinIn/JoinEmpty choice
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			registered <= '0;
			member     <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_ATTR; i++)
			begin
				registered[i] <= gar_registered(reg_q[i]);
				member[i]     <= (app_q[i] == APP_AA) || (app_q[i] == APP_QA) ||
				                 (app_q[i] == APP_PM);
			end
		end
	end

endmodule // gar_attr_reg

`default_nettype wire

// [test/gar_attr_reg_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module gar_attr_reg_properties
	import gar_pkg::*;
(
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                reduced_mode,
	input wire logic                rx_valid,
	input wire logic [2:0]          rx_msg,
	input wire logic [ATTR_W-1:0]   rx_attr,
	input wire logic                tx_opp,
	input wire logic                tx_valid,
	input wire logic [2:0]          tx_msg,
	input wire logic [ATTR_W-1:0]   tx_attr,
	input wire logic [NUM_ATTR-1:0] registered,
	input wire logic [NUM_ATTR-1:0] member
);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Sends, codes and membership tied to their causes
	a_tx_after_opp: assert property (tx_valid |-> $past(tx_opp))
		else $error("send without a slot");
	a_tx_legal_codes: assert property (tx_valid |-> tx_msg inside {1, 2, 3})
		else $error("illegal code sent");
	a_reduced_join_in: assert property (tx_valid && reduced_mode && $past(reduced_mode)
		|-> tx_msg != MSG_JOIN_EMPTY) else $error("reduced sent JoinEmpty");
	a_rx_join_regs: assert property ($past(rx_valid, 2) && $past(rx_msg, 2) inside {1, 2}
		|-> registered[$past(rx_attr, 2)]) else $error("join not registered");
	a_reg_needs_join: assert property (|(registered & ~$past(registered))
		|-> $past(rx_valid, 2) && $past(rx_msg, 2) inside {1, 2})
		else $error("registered without join");
	a_join_makes_member: assert property (tx_valid && tx_msg inside {1, 2}
		|=> member[$past(tx_attr)]) else $error("join sent, no member");
	a_leave_drops: assert property (tx_valid && tx_msg == MSG_LEAVE
		|=> !member[$past(tx_attr)]) else $error("leave sent, still member");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n
		|=> !tx_valid && member == '0) else $error("busy after reset");
endmodule // gar_attr_reg_properties

bind gar_attr_reg gar_attr_reg_properties i_props (.clk(clk), .rst_n(rst_n),
	.reduced_mode(reduced_mode), .rx_valid(rx_valid), .rx_msg(rx_msg), .rx_attr(rx_attr),
	.tx_opp(tx_opp), .tx_valid(tx_valid), .tx_msg(tx_msg), .tx_attr(tx_attr),
	.registered(registered), .member(member));
`default_nettype wire

// [test/gar_peer_model.sv]
`timescale 1ns/100ps
`default_nettype none
module gar_peer_model
	import gar_pkg::*;
(
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                drop_next,
	input wire logic                tx_valid,
	input wire logic [2:0]          tx_msg,
	input wire logic [ATTR_W-1:0]   tx_attr,
	output var logic                rx_valid,
	output var logic [2:0]          rx_msg,
	output var logic [ATTR_W-1:0]   rx_attr,
	output var logic [NUM_ATTR-1:0] peer_reg
);
	// ----------------------------------------
	// Passive peer registrar, no LeaveTime timer
	// ----------------------------------------
	initial
	begin
		rx_valid = 1'b0;
		rx_msg = 3'h7;
		rx_attr = '0;
	end

	// Lost PDUs leave no mark; a Leave keeps LV, still registered
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			peer_reg <= '0;
		else if (tx_valid && !drop_next && tx_msg inside {1, 2})
			peer_reg[tx_attr] <= 1'b1;
	end

	// One PDU from the peer; lines scrambled once released
	task automatic send(input logic [2:0] m, input logic [ATTR_W-1:0] a);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_msg <= m;
		rx_attr <= a;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_msg <= ~m;
		rx_attr <= ~a;
	endtask
endmodule // gar_peer_model
`default_nettype wire

// [test/test_gar_attr_reg.sv]
`timescale 1ns/100ps
`default_nettype none
module test_gar_attr_reg
	import gar_pkg::*;
;
	logic                clk, rst_n, reduced_mode, join_req, leave_req, tx_opp;
	logic                drop_next, rx_valid, tx_valid;
	logic [ATTR_W-1:0]   req_attr, rx_attr, tx_attr;
	logic [2:0]          rx_msg, tx_msg;
	logic [NUM_ATTR-1:0] registered, member, peer_reg;
	int                  num_errors = 0;
	int                  checks = 0;

	gar_attr_reg i_gar_attr_reg (.clk(clk), .rst_n(rst_n), .reduced_mode(reduced_mode),
		.join_req(join_req), .leave_req(leave_req), .req_attr(req_attr),
		.rx_valid(rx_valid), .rx_msg(rx_msg), .rx_attr(rx_attr), .tx_opp(tx_opp),
		.tx_valid(tx_valid), .tx_msg(tx_msg), .tx_attr(tx_attr),
		.registered(registered), .member(member));
	gar_peer_model i_gar_peer_model (.clk(clk), .rst_n(rst_n), .drop_next(drop_next),
		.tx_valid(tx_valid), .tx_msg(tx_msg), .tx_attr(tx_attr), .rx_valid(rx_valid),
		.rx_msg(rx_msg), .rx_attr(rx_attr), .peer_reg(peer_reg));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// Status levels lag their cause by two cycles
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic req(input logic j, input logic [ATTR_W-1:0] a);
		@(posedge clk);
		join_req <= j;
		leave_req <= !j;
		req_attr <= a;
		@(posedge clk);
		join_req <= 1'b0;
		leave_req <= 1'b0;
		settle;
	endtask

	// One transmit slot; unknown valid merges to a mismatch
	task automatic opp(input logic v, input logic [2:0] m, input logic [ATTR_W-1:0] a);
		@(posedge clk);
		tx_opp <= 1'b1;
		@(posedge clk);
		tx_opp <= 1'b0;
		#1;
		chk("tx", v ? {v, m, a} : 6'h0, tx_valid ? {tx_valid, tx_msg, tx_attr} : 6'h0);
	endtask

	task automatic close_out;
		if (num_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Lone joiner, peer loses the first PDU
	task automatic s_lone;
		req(1'b1, 2'h0);
		chk("member", 6'h0, {2'h0, member});
		drop_next <= 1'b1;
		opp(1'b1, MSG_JOIN_EMPTY, 2'h0);
		// Peer samples the send one edge later; keep the loss armed until then
		@(posedge clk);
		drop_next <= 1'b0;
		#1;
		chk("peer_reg", 6'h0, {2'h0, peer_reg});
		opp(1'b1, MSG_JOIN_EMPTY, 2'h0);
		opp(1'b0, MSG_NONE, 2'h0);
		chk("peer_reg", 6'h1, {2'h0, peer_reg});
		chk("member", 6'h1, {2'h0, member});
	endtask

	// One other member, then a JoinEmpty answered in QA
	task automatic s_one;
		i_gar_peer_model.send(MSG_JOIN_EMPTY, 2'h1);
		settle;
		chk("registered", 6'h2, {2'h0, registered});
		req(1'b1, 2'h1);
		opp(1'b1, MSG_JOIN_IN, 2'h1);
		opp(1'b1, MSG_JOIN_IN, 2'h1);
		i_gar_peer_model.send(MSG_JOIN_EMPTY, 2'h0);
		settle;
		opp(1'b1, MSG_JOIN_IN, 2'h0);
	endtask

	// Two joins heard: silent join and silent leave
	task automatic s_passive;
		i_gar_peer_model.send(MSG_JOIN_IN, 2'h2);
		i_gar_peer_model.send(MSG_JOIN_IN, 2'h2);
		req(1'b1, 2'h2);
		chk("member", 6'h7, {2'h0, member});
		opp(1'b0, MSG_NONE, 2'h0);
		req(1'b0, 2'h2);
		opp(1'b0, MSG_NONE, 2'h0);
		chk("member", 6'h3, {2'h0, member});
		// LeaveAll forgets the heard joins, so the next join is sent, as JoinIn from LV
		i_gar_peer_model.send(MSG_LEAVE_ALL, 2'h2);
		req(1'b1, 2'h2);
		opp(1'b1, MSG_JOIN_IN, 2'h2);
		opp(1'b1, MSG_JOIN_IN, 2'h2);
		chk("member", 6'h7, {2'h0, member});
	endtask

	// Reduced applicant; a heard Leave keeps registration
	task automatic s_reduced;
		@(posedge clk);
		reduced_mode <= 1'b1;
		req(1'b1, 2'h3);
		opp(1'b1, MSG_JOIN_IN, 2'h3);
		opp(1'b1, MSG_JOIN_IN, 2'h3);
		req(1'b0, 2'h3);
		opp(1'b1, MSG_LEAVE, 2'h3);
		opp(1'b0, MSG_NONE, 2'h0);
		i_gar_peer_model.send(MSG_LEAVE, 2'h1);
		settle;
		chk("registered", 6'h7, {2'h0, registered});
	endtask

	// Clock, reset, run and watchdog
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial
	begin
		rst_n = 1'b0;
		reduced_mode = 1'b0;
		join_req = 1'b0;
		leave_req = 1'b0;
		req_attr = '0;
		tx_opp = 1'b0;
		drop_next = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		s_lone;
		s_one;
		s_passive;
		s_reduced;
		close_out;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out;
	end
endmodule // test_gar_attr_reg
`default_nettype wire
